/* File: rtl/pslv_top.sv */
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
// ==========================================================
// Contract
// - Enable bit selects slave port, else GPIO.
// - Enable turns control pins into strobes.
// - Separate inbound and outbound latches, one address.
// - Slave mode ignores data direction register.
// - Write: select and write low, capture.
// - Write end sets input full later.
// - Write end sets interrupt flag too.
// - CPU data read clears input full.
// - Write while full sets overrun, keeps byte.
// - Overrun sticks until software writes zero.
// - Read: drive latch, clear output full.
// - Read end sets interrupt flag later.
// - CPU write sets output full.
// - Disabled mode holds both full flags clear.
// - Interrupt flag latched, request needs enable.
// - Sleep still completes transfers, wakes.
// - Reset disables slave port mode.
// - High select ignores all strobes.
// - Control directions: one input, reset one.

module pslv_top (
   input  wire logic        clock_i,     // System clock, 100 MHz.
   input  wire logic        rst_i,       // Synchronous reset.
   input  wire logic        ce_i,        // Clock enable.
   input  wire logic        wb_cyc_i,    // Bus cycle.
   input  wire logic        wb_stb_i,    // Bus strobe.
   input  wire logic        wb_we_i,     // Bus write.
   input  wire logic [7:0]  wb_adr_i,    // Byte address.
   input  wire logic [31:0] wb_dat_i,    // Write data.
   input  wire logic [3:0]  wb_sel_i,    // Byte enables.
   output logic      [31:0] wb_dat_o,    // Read data.
   output logic             wb_ack_o,    // Acknowledge.
   input  wire logic [7:0]  data_in_i,   // Data pin levels.
   output logic      [7:0]  data_out_o,  // Data pin drive.
   output logic      [7:0]  data_oe_n_o, // Data enable, low drives.
   input  wire logic [2:0]  ctrl_in_i,   // Control pin levels.
   output logic      [2:0]  ctrl_out_o,  // Control pin drive.
   output logic      [2:0]  ctrl_oe_n_o, // Control enable, low drives.
   input  wire logic        sleep_i,     // Processor asleep.
   output logic             irq_req_o,   // Interrupt request.
   output logic             wake_o       // Wake from sleep.
);

   // ==========================================================
   // Address decode shared by reads and writes.
   function automatic logic reg_hit(input logic [7:0] adr,
                                    input logic [7:0] off);
      reg_hit = (adr[7:2] == off[7:2]);
   endfunction : reg_hit

   // ==========================================================
   // Declarations.
   pslv_pkg::pslv_state_t st_reg;
   pslv_pkg::pslv_state_t st_next;
   pslv_pkg::pslv_pins_t  raw;
   pslv_pkg::pslv_pins_t  syn;
   logic                  phase_two;
   logic                  phase_four;
   logic                  req;
   logic                  first;
   logic                  wr_go;
   logic                  rd_first;
   logic [7:0]            wdat;
   logic                  rd_drive;
   logic                  sel;

   // ==========================================================
   // Strobes and data enter through the synchroniser together,
   // so captured data keeps step with the strobes.
   assign raw = {ctrl_in_i, data_in_i};

   pslv_sync u_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .pins_i  (raw),
      .pins_o  (syn)
   );

   // Instruction clock phases.
   pslv_phase u_phase (
      .clock_i      (clock_i),
      .rst_i        (rst_i),
      .ce_i         (ce_i),
      .phase_two_o  (phase_two),
      .phase_four_o (phase_four)
   );

   // ==========================================================
   // Bus request qualifiers.
   assign req      = wb_cyc_i & wb_stb_i;
   assign first    = req & ~st_reg.ack;
   assign wr_go    = req & st_reg.ack & wb_we_i & wb_sel_i[0];
   assign rd_first = first & ~wb_we_i;
   assign wdat     = wb_dat_i[7:0];
   assign sel      = ~syn.cs_n;

   // ==========================================================
   // Next state: bus, software effects, then the transfer FSM,
   // so that hardware sets override software clears.
   always_comb begin
      st_next     = st_reg;
      st_next.ack = first;

      // Read data is captured in the first cycle of a request.
      if (first) begin
         st_next.rdata = 8'h00;
         if (reg_hit(wb_adr_i, pslv_pkg::ADR_DATA)) begin
            st_next.rdata = st_reg.mode ? st_reg.in_latch
                                        : syn.data;
         end else if (reg_hit(wb_adr_i, pslv_pkg::ADR_CSD)) begin
            st_next.rdata = {st_reg.input_full_flag, st_reg.output_full_flag, st_reg.ovr,
                             st_reg.mode, 1'h0, st_reg.cdir};
         end else if (reg_hit(wb_adr_i, pslv_pkg::ADR_DDIR)) begin
            st_next.rdata = st_reg.ddir;
         end else if (reg_hit(wb_adr_i, pslv_pkg::ADR_CLAT)) begin
            st_next.rdata = {5'h00, syn.cs_n, syn.wr_n, syn.rd_n};
         end else if (reg_hit(wb_adr_i, pslv_pkg::ADR_IRQ)) begin
            st_next.rdata = {6'h00, st_reg.irq_en, st_reg.irq_flag};
         end
      end

      // Reading the inbound latch empties it.
      if (rd_first && st_reg.mode &&
          reg_hit(wb_adr_i, pslv_pkg::ADR_DATA)) begin
         st_next.input_full_flag = 1'h0;
      end

      // Software writes take effect at the acknowledge edge.
      if (wr_go) begin
         if (reg_hit(wb_adr_i, pslv_pkg::ADR_DATA)) begin
            st_next.out_latch = wdat;
            st_next.output_full_flag       = 1'h1;
         end else if (reg_hit(wb_adr_i, pslv_pkg::ADR_CSD)) begin
            st_next.mode = wdat[pslv_pkg::CSD_MODE];
            st_next.cdir = wdat[2:0];
            if (!wdat[pslv_pkg::CSD_OVR]) begin
               st_next.ovr = 1'h0;
            end
         end else if (reg_hit(wb_adr_i, pslv_pkg::ADR_DDIR)) begin
            st_next.ddir = wdat;
         end else if (reg_hit(wb_adr_i, pslv_pkg::ADR_CLAT)) begin
            st_next.clat = wdat[2:0];
         end else if (reg_hit(wb_adr_i, pslv_pkg::ADR_IRQ)) begin
            st_next.irq_en = wdat[pslv_pkg::IRQ_EN];
            if (!wdat[pslv_pkg::IRQ_FLAG]) begin
               st_next.irq_flag = 1'h0;
            end
         end
      end

      // External transfers run only in slave mode, sleep or not.
      if (st_reg.mode) begin
         case (st_reg.xfer)
            pslv_pkg::PS_IDLE: begin
               if (sel && !syn.wr_n) begin
                  st_next.xfer  = pslv_pkg::PS_ACTIVE;
                  st_next.is_wr = 1'h1;
                  st_next.stage = syn.data;
               end else if (sel && !syn.rd_n) begin
                  st_next.xfer  = pslv_pkg::PS_ACTIVE;
                  st_next.is_wr = 1'h0;
                  st_next.output_full_flag   = 1'h0;
               end
            end
            pslv_pkg::PS_ACTIVE: begin
               if (st_reg.is_wr) begin
                  if (syn.cs_n || syn.wr_n) begin
                     st_next.xfer = pslv_pkg::PS_WAIT_TWO;
                  end else begin
                     st_next.stage = syn.data;
                  end
               end else if (syn.cs_n || syn.rd_n) begin
                  st_next.xfer = pslv_pkg::PS_WAIT_TWO;
               end
            end
            pslv_pkg::PS_WAIT_TWO: begin
               if (phase_two) begin
                  st_next.xfer = pslv_pkg::PS_WAIT_FOUR;
               end
            end
            pslv_pkg::PS_WAIT_FOUR: begin
               if (phase_four) begin
                  st_next.xfer     = pslv_pkg::PS_IDLE;
                  st_next.irq_flag = 1'h1;
                  if (st_reg.is_wr && st_reg.input_full_flag) begin
                     st_next.ovr = 1'h1;
                  end else if (st_reg.is_wr) begin
                     st_next.in_latch = st_reg.stage;
                     st_next.input_full_flag      = 1'h1;
                  end
               end
            end
            default: begin
               st_next.xfer = pslv_pkg::PS_IDLE;
            end
         endcase
      end

      // Leaving or staying out of slave mode empties both flags.
      if (!st_next.mode) begin
         st_next.input_full_flag  = 1'h0;
         st_next.output_full_flag  = 1'h0;
         st_next.xfer = pslv_pkg::PS_IDLE;
      end
   end

   // ==========================================================
   // State register; any reset returns to plain I/O.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_reg <= pslv_pkg::ST_RST;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Pins. A selected read drives the outbound latch; otherwise
   // slave mode leaves all pins as inputs whatever the directions.
   assign rd_drive    = st_reg.mode & sel & ~syn.rd_n;
   assign data_out_o  = st_reg.out_latch;
   assign data_oe_n_o = st_reg.mode ? {8{~rd_drive}}
                                    : st_reg.ddir;
   assign ctrl_out_o  = st_reg.clat;
   assign ctrl_oe_n_o = st_reg.mode ? 3'h7
                                    : st_reg.cdir;

   // Interrupt request and wake.
   assign irq_req_o = st_reg.irq_flag & st_reg.irq_en;
   assign wake_o    = irq_req_o & sleep_i;

   // Bus answer.
   assign wb_dat_o = {24'h000000, st_reg.rdata};
   assign wb_ack_o = st_reg.ack;

   // ==========================================================
   // Assertions.
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   logic end_step;
   assign end_step = ce_i && st_reg.mode && !wr_go &&
                     st_reg.xfer == pslv_pkg::PS_WAIT_FOUR &&
                     phase_four;

   flags_off_a: assert property (
      !st_reg.mode |-> !st_reg.input_full_flag && !st_reg.output_full_flag)
      else $error("full flag set outside slave mode");

   rd_drive_a: assert property (
      (st_reg.mode && sel && !syn.rd_n) |->
         data_oe_n_o == 8'h00 && data_out_o == st_reg.out_latch)
      else $error("read strobe did not drive the bus");

   deselect_a: assert property (
      (st_reg.mode && syn.cs_n) |->
         data_oe_n_o == 8'hFF && ctrl_oe_n_o == 3'h7)
      else $error("deselected port drives pins");

   gpio_dir_a: assert property (
      !st_reg.mode |-> data_oe_n_o == st_reg.ddir &&
                       ctrl_oe_n_o == st_reg.cdir)
      else $error("I/O direction not followed");

   ibf_set_a: assert property (
      (end_step && st_reg.is_wr && !st_reg.input_full_flag) |=>
         st_reg.input_full_flag && st_reg.in_latch == $past(st_reg.stage))
      else $error("write completion did not fill latch");

   wr_irq_a: assert property (
      (end_step && st_reg.is_wr) |=> st_reg.irq_flag)
      else $error("write completion left irq flag low");

   rd_irq_a: assert property (
      (end_step && !st_reg.is_wr && !st_reg.output_full_flag) |=>
         st_reg.irq_flag && !st_reg.output_full_flag)
      else $error("read completion left irq flag low");

   overrun_a: assert property (
      (end_step && st_reg.is_wr && st_reg.input_full_flag) |=>
         st_reg.ovr && $stable(st_reg.in_latch))
      else $error("overrun not flagged or byte lost");

   ovr_sticky_a: assert property (
      (st_reg.ovr && !(wr_go && reg_hit(wb_adr_i, pslv_pkg::ADR_CSD)))
         |=> st_reg.ovr)
      else $error("overrun cleared by hardware");

   ack_pulse_a: assert property (
      (wb_ack_o && ce_i) |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");

   write_done_c: cover property (end_step && st_reg.is_wr);
   read_done_c:  cover property (end_step && !st_reg.is_wr);
   overrun_c:    cover property (end_step && st_reg.is_wr && st_reg.input_full_flag);
   wake_c:       cover property (wake_o);

endmodule : pslv_top

/* File: rtl/pslv_pkg.sv */
package pslv_pkg;

   // ==========================================================
   // Register map, byte addresses on the bus.
   localparam logic [7:0] ADR_DATA = 8'h00;
   localparam logic [7:0] ADR_CSD  = 8'h04;
   localparam logic [7:0] ADR_DDIR = 8'h08;
   localparam logic [7:0] ADR_CLAT = 8'h0C;
   localparam logic [7:0] ADR_IRQ  = 8'h10;

   // ==========================================================
   // Field positions.
   localparam int CSD_IBF  = 7;
   localparam int CSD_OBF  = 6;
   localparam int CSD_OVR  = 5;
   localparam int CSD_MODE = 4;
   localparam int IRQ_FLAG = 0;
   localparam int IRQ_EN   = 1;

   // ==========================================================
   // Values after reset and phase counts.
   localparam logic [7:0] DDIR_RST  = 8'hFF;
   localparam logic [2:0] CDIR_RST  = 3'h7;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [1:0] PH_RST    = 2'h0;
   localparam logic [1:0] PH_TWO    = 2'h1;
   localparam logic [1:0] PH_FOUR   = 2'h3;

   // ==========================================================
   // Types.
   typedef enum logic [1:0] {
      PS_IDLE      = 2'h0,
      PS_ACTIVE    = 2'h1,
      PS_WAIT_TWO  = 2'h3,
      PS_WAIT_FOUR = 2'h2
   } pslv_xfer_t;

   // Strobes and data of the external bus; order matches the pins.
   typedef struct packed {
      logic       cs_n;
      logic       wr_n;
      logic       rd_n;
      logic [7:0] data;
   } pslv_pins_t;

   localparam pslv_pins_t PINS_IDLE = '{cs_n: 1'h1, wr_n: 1'h1,
                                        rd_n: 1'h1, data: 8'h00};

   typedef struct packed {
      pslv_pins_t meta;
      pslv_pins_t stable;
   } pslv_sync_st_t;

   typedef struct packed {
      logic [1:0] cnt;
   } pslv_phase_st_t;

   typedef struct packed {
      pslv_xfer_t xfer;
      logic       is_wr;
      logic       mode;
      logic       input_full_flag;
      logic       output_full_flag;
      logic       ovr;
      logic [2:0] cdir;
      logic [7:0] ddir;
      logic [7:0] in_latch;
      logic [7:0] out_latch;
      logic [7:0] stage;
      logic [2:0] clat;
      logic       irq_flag;
      logic       irq_en;
      logic       ack;
      logic [7:0] rdata;
   } pslv_state_t;

   localparam pslv_state_t ST_RST = '{
      xfer: PS_IDLE, is_wr: 1'h0, mode: 1'h0, input_full_flag: 1'h0, output_full_flag: 1'h0,
      ovr: 1'h0, cdir: CDIR_RST, ddir: DDIR_RST, in_latch: LATCH_RST,
      out_latch: LATCH_RST, stage: LATCH_RST, clat: 3'h0,
      irq_flag: 1'h0, irq_en: 1'h0, ack: 1'h0, rdata: 8'h00};

endpackage : pslv_pkg

/* File: rtl/pslv_sync.sv */
`timescale 1ns/1ps

module pslv_sync (
   input  wire logic                clock_i, // System clock.
   input  wire logic                rst_i,   // Synchronous reset.
   input  wire logic                ce_i,    // Clock enable.
   input  wire pslv_pkg::pslv_pins_t pins_i, // Raw strobes and data.
   output pslv_pkg::pslv_pins_t      pins_o  // Synchronised copy.
);

   // ==========================================================
   // Two stages; the first stage feeds only the second.
   pslv_pkg::pslv_sync_st_t st_reg;
   pslv_pkg::pslv_sync_st_t st_next;

   // Next state shifts the pins through both stages.
   always_comb begin
      st_next        = st_reg;
      st_next.meta   = pins_i;
      st_next.stable = st_reg.meta;
   end

   // State register, idle strobes after reset.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_reg <= '{meta: pslv_pkg::PINS_IDLE,
                     stable: pslv_pkg::PINS_IDLE};
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   // Only the second stage is visible.
   assign pins_o = st_reg.stable;

endmodule : pslv_sync

/* File: rtl/pslv_phase.sv */
`timescale 1ns/1ps

module pslv_phase (
   input  wire logic clock_i,      // System clock.
   input  wire logic rst_i,        // Synchronous reset.
   input  wire logic ce_i,         // Clock enable.
   output logic      phase_two_o,  // High in the second phase.
   output logic      phase_four_o  // High in the fourth phase.
);

   // ==========================================================
   // Four phases make one instruction cycle.
   pslv_pkg::pslv_phase_st_t st_reg;
   pslv_pkg::pslv_phase_st_t st_next;

   // The counter wraps from the fourth phase to the first.
   always_comb begin
      st_next     = st_reg;
      st_next.cnt = st_reg.cnt + 2'h1;
   end

   // State register.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_reg.cnt <= pslv_pkg::PH_RST;
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   // Phase decode.
   assign phase_two_o  = (st_reg.cnt == pslv_pkg::PH_TWO);
   assign phase_four_o = (st_reg.cnt == pslv_pkg::PH_FOUR);

   // One phase separates the second and fourth phase.
   two_to_four_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (phase_two_o && ce_i) |=> !phase_four_o && !phase_two_o)
      else $error("phase order broken");

endmodule : pslv_phase

/* File: testbench/pslv_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// External byte-wide bus master that talks to the slave port.
module pslv_host_model (
   input  wire logic       clock_i,    // System clock.
   input  wire logic [7:0] dev_dat_i,  // Device drive value.
   input  wire logic [7:0] dev_oe_n_i, // Device enable, low drives.
   output logic      [2:0] strobe_o,   // Select, write, read; low on.
   output logic      [7:0] bus_o       // Resolved data bus level.
);
   logic       drv;
   logic [7:0] dat;
   logic [7:0] flt;

   // Start with the bus released and the strobes idle.
   initial begin
      strobe_o = 3'h7;
      drv      = 1'b0;
      dat      = 8'h00;
      flt      = 8'hA5;
   end

   // A released bit shows a pattern that changes every cycle.
   always @(posedge clock_i) begin
      flt <= ~flt;
   end

   // A bit carries the device's value where it drives, else ours.
   assign bus_o = (~dev_oe_n_i & dev_dat_i)
                | (dev_oe_n_i & (drv ? dat : flt));

   // One transfer: strobe low for hold plus one cycles, then a quiet gap.
   task automatic xfer(input  logic       wr,
                       input  logic       sel,
                       input  logic [7:0] d,
                       input  int         hold,
                       output logic [7:0] got);
      @(posedge clock_i);
      strobe_o <= {~sel, ~wr, wr};
      drv      <= wr;
      dat      <= d;
      repeat (hold) @(posedge clock_i);
      @(negedge clock_i);
      got = bus_o;
      @(posedge clock_i);
      strobe_o <= 3'h7;
      @(posedge clock_i);
      drv <= 1'b0;
      repeat (10) @(posedge clock_i);
   endtask : xfer
endmodule : pslv_host_model

/* File: testbench/pslv_top_test.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the parallel slave port.
module pslv_top_test;
   logic        clk   = 1'b0;
   logic        rst   = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] wdat  = 32'h0;
   logic [3:0]  sel   = 4'h0;
   logic        sleep = 1'b0;
   logic [31:0] seed  = 32'hEAA2;
   int          err_count = 0;
   int          checked   = 0;
   wire  [31:0] rdat;
   wire         ack;
   wire  [7:0]  dout;
   wire  [7:0]  doe_n;
   wire  [7:0]  bus;
   wire  [2:0]  cout;
   wire  [2:0]  coe_n;
   wire  [2:0]  strobe;
   wire  [2:0]  cin;
   wire         irq;
   wire         wake;

   // Clock of 100 MHz.
   always #5 clk = ~clk;

   // A control pin shows the device where it drives, else the host.
   assign cin = (~coe_n & cout) | (coe_n & strobe);

   pslv_top uut (
      .clock_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
      .data_in_i(bus), .data_out_o(dout), .data_oe_n_o(doe_n),
      .ctrl_in_i(cin), .ctrl_out_o(cout), .ctrl_oe_n_o(coe_n),
      .sleep_i(sleep), .irq_req_o(irq), .wake_o(wake));

   pslv_host_model host (
      .clock_i(clk), .dev_dat_i(dout), .dev_oe_n_i(doe_n),
      .strobe_o(strobe), .bus_o(bus));

   // ==========================================================
   // Helpers.
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : xs

   // Expected status byte, with all control pins as inputs.
   function automatic logic [7:0] csd(input logic i, o, v, m);
      return {i, o, v, m, 4'h7};
   endfunction : csd

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One classic Wishbone cycle. The request holds until a rising
   // edge samples ack high; read data is taken at that same edge.
   // Only the watchdog bounds the wait.
   task automatic wb(input  logic w, input logic [7:0] a,
                     input  logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= {24'h0, d};
      sel  <= 4'hF;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat[7:0];
      chk(rdat[31:8], 24'h0);
      cyc <= 1'b0;
      we  <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rd

   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   // Watchdog that cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out();
   end

   // ==========================================================
   // Main sequence.
   initial begin
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] g;
      int         k;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(pslv_pkg::ADR_CSD, 8'h07);
      rd(pslv_pkg::ADR_DDIR, 8'hFF);
      rd(pslv_pkg::ADR_IRQ, 8'h00);
      rd(8'h14, 8'h00);
      @(negedge clk);
      chk({coe_n, doe_n}, 11'h7FF);
      // Plain port use while slave mode is off.
      wr(pslv_pkg::ADR_DDIR, 8'h00);
      wr(pslv_pkg::ADR_DATA, 8'h5A);
      wr(pslv_pkg::ADR_CLAT, 8'h05);
      wr(pslv_pkg::ADR_CSD, 8'hE2);
      @(negedge clk);
      chk({doe_n, dout, cout}, 19'h002D5);
      chk(coe_n, 3'h2);
      rd(pslv_pkg::ADR_CSD, 8'h02);
      wr(pslv_pkg::ADR_CSD, 8'h07);
      host.xfer(1'b1, 1'b1, 8'h33, 4, g);
      rd(pslv_pkg::ADR_CSD, 8'h07);
      rd(pslv_pkg::ADR_IRQ, 8'h00);
      // Slave mode with the interrupt enabled.
      wr(pslv_pkg::ADR_CSD, 8'h17);
      wr(pslv_pkg::ADR_IRQ, 8'h02);
      @(negedge clk);
      chk({coe_n, doe_n}, 11'h7FF);
      for (k = 0; k < 6; k++) begin
         b = xs();
         sleep <= k[0];
         host.xfer(1'b1, 1'b1, b, 3 + int'(xs() & 8'h03), g);
         @(negedge clk);
         chk({wake, irq}, {k[0], 1'b1});
         rd(pslv_pkg::ADR_CSD, csd(1, 0, 0, 1));
         rd(pslv_pkg::ADR_DATA, b);
         rd(pslv_pkg::ADR_CSD, csd(0, 0, 0, 1));
         wr(pslv_pkg::ADR_IRQ, 8'h02);
         c = xs();
         wr(pslv_pkg::ADR_DATA, c);
         rd(pslv_pkg::ADR_CSD, csd(0, 1, 0, 1));
         host.xfer(1'b0, 1'b1, 8'h00, 3 + int'(xs() & 8'h03), g);
         chk(g, c);
         rd(pslv_pkg::ADR_IRQ, 8'h03);
         rd(pslv_pkg::ADR_CSD, csd(0, 0, 0, 1));
         wr(pslv_pkg::ADR_IRQ, 8'h02);
      end
      sleep <= 1'b0;
      // Interrupt masked, then an overrun and its sticky flag.
      wr(pslv_pkg::ADR_IRQ, 8'h00);
      host.xfer(1'b1, 1'b1, 8'hC3, 3, g);
      host.xfer(1'b1, 1'b1, 8'h3C, 6, g);
      @(negedge clk);
      chk(irq, 1'b0);
      rd(pslv_pkg::ADR_IRQ, 8'h01);
      wr(pslv_pkg::ADR_DATA, 8'h99);
      rd(pslv_pkg::ADR_CSD, csd(1, 1, 1, 1));
      rd(pslv_pkg::ADR_DATA, 8'hC3);
      wr(pslv_pkg::ADR_CSD, 8'h27);
      rd(pslv_pkg::ADR_CSD, csd(0, 0, 1, 0));
      wr(pslv_pkg::ADR_CSD, 8'h37);
      rd(pslv_pkg::ADR_CSD, csd(0, 0, 1, 1));
      wr(pslv_pkg::ADR_CSD, 8'h17);
      rd(pslv_pkg::ADR_CSD, csd(0, 0, 0, 1));
      // Strobes while deselected change nothing.
      wr(pslv_pkg::ADR_IRQ, 8'h00);
      wr(pslv_pkg::ADR_DATA, 8'h66);
      host.xfer(1'b1, 1'b0, 8'h5C, 4, g);
      host.xfer(1'b0, 1'b0, 8'h00, 4, g);
      rd(pslv_pkg::ADR_CSD, csd(0, 1, 0, 1));
      rd(pslv_pkg::ADR_IRQ, 8'h00);
      // Reset in mid-run leaves slave mode.
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(pslv_pkg::ADR_CSD, 8'h07);
      @(negedge clk);
      chk(doe_n, 8'hFF);
      close_out();
   end
endmodule : pslv_top_test
